// ==== hdl/cig_top.v ====
// Purpose: interrupt enable register and gating for a can controller
// Assumes: status inputs come from logic on hclk; ahb-lite single slave
// Notes:   zero wait state slave, response always okay
`timescale 1ns/1ps
`include "cig_regs.vh"

module cig_top #(
  parameter CNT_W = 2,
  parameter TXMB_N = 3
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [TXMB_N-1:0] tx_request_done,
  input wire [CNT_W-1:0] rx0_msg_count,
  input wire rx0_msg_arrive,
  input wire [CNT_W-1:0] rx1_msg_count,
  input wire rx1_msg_arrive,
  input wire [8:0] tx_fault_counter,
  input wire [7:0] rx_fault_counter,
  input wire [2:0] last_fault_code,
  input wire last_code_update,
  input wire wake_event,
  input wire doze_ack_event,
  output reg irq_tx,
  output reg irq_rx0,
  output reg irq_rx1,
  output reg irq_err,
  output reg irq_wake,
  output reg irq_doze,
  output wire warning_state,
  output wire passive_state,
  output wire busoff_state
);

  ////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  reg wr_pend_r;
  reg [`CIG_ADDR_W-1:0] wr_addr_r;
  reg [31:0] inten_r;
  reg [31:0] inten_nxt;
  reg [31:0] rdata_nxt;
  wire addr_ok;
  wire rd_req;
  wire wr_req;
  wire [`CIG_ADDR_W-1:0] a_addr;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a_addr = haddr[`CIG_ADDR_W-1:0];
  assign addr_ok = hsel && hready &&
    (htrans == `CIG_HTRANS_NONSEQ || htrans == `CIG_HTRANS_SEQ);
  assign rd_req = addr_ok && !hwrite;
  assign wr_req = addr_ok && hwrite;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {`CIG_ADDR_W{1'b0}};
    end else begin
      wr_pend_r <= wr_req;
      if (wr_req) begin
        wr_addr_r <= a_addr;
      end
    end
  end

  // one-cycle write strobes decoded in the data phase
  wire wr_msts;
  wire wr_rxf0;
  wire wr_rxf1;
  wire wr_inten;

  assign wr_msts = wr_pend_r && (wr_addr_r == `CIG_OFS_MSTS);
  assign wr_rxf0 = wr_pend_r && (wr_addr_r == `CIG_OFS_RXF0);
  assign wr_rxf1 = wr_pend_r && (wr_addr_r == `CIG_OFS_RXF1);
  assign wr_inten = wr_pend_r && (wr_addr_r == `CIG_OFS_INTEN);

  ////////////////////////////////////////////////////////////////////
  // interrupt enable register
  always @* begin
    inten_nxt = inten_r;
    if (wr_inten) begin
      inten_nxt = hwdata & `CIG_INTEN_MASK;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inten_r <= `CIG_INTEN_RST;
    end else begin
      inten_r <= inten_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // error state derived from the fault counters
  wire [8:0] rx_cnt_ext;

  assign rx_cnt_ext = {1'b0, rx_fault_counter};
  assign warning_state = (tx_fault_counter >= `CIG_WARN_LIMIT) ||
    (rx_cnt_ext >= `CIG_WARN_LIMIT);
  assign passive_state = (tx_fault_counter >= `CIG_PASV_LIMIT) ||
    (rx_cnt_ext >= `CIG_PASV_LIMIT);
  assign busoff_state = (tx_fault_counter > `CIG_BOFF_LIMIT);

  ////////////////////////////////////////////////////////////////////
  // receive fifo full and overrun flags
  wire rx0_full;
  wire rx0_overrun;
  wire rx1_full;
  wire rx1_overrun;
  wire rx0_at_full;
  wire rx1_at_full;

  assign rx0_at_full = (rx0_msg_count == `CIG_FIFO_FULL_CNT);
  assign rx1_at_full = (rx1_msg_count == `CIG_FIFO_FULL_CNT);

  cig_sticky u_rx0_full (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rx0_at_full),
    .clr(wr_rxf0 && hwdata[`CIG_RXF_FULL]),
    .flag_r(rx0_full)
  );

  cig_sticky u_rx0_ovr (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rx0_at_full && rx0_msg_arrive),
    .clr(wr_rxf0 && hwdata[`CIG_RXF_OVR]),
    .flag_r(rx0_overrun)
  );

  cig_sticky u_rx1_full (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rx1_at_full),
    .clr(wr_rxf1 && hwdata[`CIG_RXF_FULL]),
    .flag_r(rx1_full)
  );

  cig_sticky u_rx1_ovr (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rx1_at_full && rx1_msg_arrive),
    .clr(wr_rxf1 && hwdata[`CIG_RXF_OVR]),
    .flag_r(rx1_overrun)
  );

  ////////////////////////////////////////////////////////////////////
  // error interrupt flag
  wire fault_set;
  wire fault_irq_flag;
  reg [2:0] lec_r;

  assign fault_set =
    (warning_state && inten_r[`CIG_EN_WARN]) ||
    (passive_state && inten_r[`CIG_EN_PASV]) ||
    (busoff_state && inten_r[`CIG_EN_BOFF]) ||
    (last_code_update && inten_r[`CIG_EN_LEC]);

  cig_sticky u_fault (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(fault_set),
    .clr(wr_msts && hwdata[`CIG_MSTS_FAULT]),
    .flag_r(fault_irq_flag)
  );

  // last error code as recorded by the update strobe
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lec_r <= `CIG_LEC_RST;
    end else if (last_code_update) begin
      lec_r <= last_fault_code;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // gated requests, registered levels
  wire tx_req_nxt;
  wire rx0_req_nxt;
  wire rx1_req_nxt;
  wire err_req_nxt;
  wire wake_req_nxt;
  wire doze_req_nxt;

  assign tx_req_nxt = (|tx_request_done) && inten_r[`CIG_EN_TXE];
  assign rx0_req_nxt =
    ((|rx0_msg_count) && inten_r[`CIG_EN_RX0P]) ||
    (rx0_full && inten_r[`CIG_EN_RX0F]) ||
    (rx0_overrun && inten_r[`CIG_EN_RX0O]);
  assign rx1_req_nxt =
    ((|rx1_msg_count) && inten_r[`CIG_EN_RX1P]) ||
    (rx1_full && inten_r[`CIG_EN_RX1F]) ||
    (rx1_overrun && inten_r[`CIG_EN_RX1O]);
  // the flag drives the request, so it holds until software clears it
  assign err_req_nxt = fault_irq_flag && inten_r[`CIG_EN_ERR];
  assign wake_req_nxt = wake_event && inten_r[`CIG_EN_WAKE];
  assign doze_req_nxt = doze_ack_event && inten_r[`CIG_EN_DOZE];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_tx <= 1'b0;
      irq_rx0 <= 1'b0;
      irq_rx1 <= 1'b0;
      irq_err <= 1'b0;
      irq_wake <= 1'b0;
      irq_doze <= 1'b0;
    end else begin
      irq_tx <= tx_req_nxt;
      irq_rx0 <= rx0_req_nxt;
      irq_rx1 <= rx1_req_nxt;
      irq_err <= err_req_nxt;
      irq_wake <= wake_req_nxt;
      irq_doze <= doze_req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, sampled in the address phase
  always @* begin
    rdata_nxt = 32'h00000000;
    case (a_addr)
      `CIG_OFS_MSTS: begin
        rdata_nxt[`CIG_MSTS_FAULT] = fault_irq_flag;
        rdata_nxt[`CIG_MSTS_WAKE] = wake_event;
        rdata_nxt[`CIG_MSTS_DOZE] = doze_ack_event;
      end
      `CIG_OFS_TSTS: begin
        rdata_nxt[TXMB_N-1:0] = tx_request_done;
      end
      `CIG_OFS_RXF0: begin
        rdata_nxt[CNT_W-1:0] = rx0_msg_count;
        rdata_nxt[`CIG_RXF_FULL] = rx0_full;
        rdata_nxt[`CIG_RXF_OVR] = rx0_overrun;
      end
      `CIG_OFS_RXF1: begin
        rdata_nxt[CNT_W-1:0] = rx1_msg_count;
        rdata_nxt[`CIG_RXF_FULL] = rx1_full;
        rdata_nxt[`CIG_RXF_OVR] = rx1_overrun;
      end
      `CIG_OFS_INTEN: begin
        rdata_nxt = inten_r & `CIG_INTEN_MASK;
      end
      `CIG_OFS_ERRS: begin
        rdata_nxt[`CIG_ERRS_WARN] = warning_state;
        rdata_nxt[`CIG_ERRS_PASV] = passive_state;
        rdata_nxt[`CIG_ERRS_BOFF] = busoff_state;
        rdata_nxt[`CIG_ERRS_LEC_LO+2:`CIG_ERRS_LEC_LO] = lec_r;
        rdata_nxt[`CIG_ERRS_TXC_LO+7:`CIG_ERRS_TXC_LO] =
          tx_fault_counter[7:0];
        rdata_nxt[`CIG_ERRS_RXC_LO+7:`CIG_ERRS_RXC_LO] = rx_fault_counter;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CIG_RDATA_RST;
    end else if (rd_req) begin
      hrdata <= rdata_nxt;
    end
  end

endmodule // cig_top

// ==== hdl/cig_regs.vh ====
// Purpose: register map, field positions and limits of the can
//          interrupt enable and gating block
// Assumes: word-aligned 32-bit registers on an ahb-lite bus
// Notes:   definitions only
`ifndef CIG_REGS_VH
`define CIG_REGS_VH

////////////////////////////////////////////////////////////////////////
// byte offsets
`define CIG_OFS_MSTS 8'h04
`define CIG_OFS_TSTS 8'h08
`define CIG_OFS_RXF0 8'h0C
`define CIG_OFS_RXF1 8'h10
`define CIG_OFS_INTEN 8'h14
`define CIG_OFS_ERRS 8'h18
`define CIG_ADDR_W 8

////////////////////////////////////////////////////////////////////////
// interrupt enable fields
`define CIG_INTEN_RST 32'h00000000
`define CIG_INTEN_MASK 32'h00038F7F
`define CIG_EN_TXE 0
`define CIG_EN_RX0P 1
`define CIG_EN_RX0F 2
`define CIG_EN_RX0O 3
`define CIG_EN_RX1P 4
`define CIG_EN_RX1F 5
`define CIG_EN_RX1O 6
`define CIG_EN_WARN 8
`define CIG_EN_PASV 9
`define CIG_EN_BOFF 10
`define CIG_EN_LEC 11
`define CIG_EN_ERR 15
`define CIG_EN_WAKE 16
`define CIG_EN_DOZE 17

////////////////////////////////////////////////////////////////////////
// status fields
`define CIG_MSTS_FAULT 2
`define CIG_MSTS_WAKE 3
`define CIG_MSTS_DOZE 4
`define CIG_RXF_CNT_LO 0
`define CIG_RXF_FULL 3
`define CIG_RXF_OVR 4
`define CIG_ERRS_WARN 0
`define CIG_ERRS_PASV 1
`define CIG_ERRS_BOFF 2
`define CIG_ERRS_LEC_LO 4
`define CIG_ERRS_TXC_LO 16
`define CIG_ERRS_RXC_LO 24

////////////////////////////////////////////////////////////////////////
// limits
`define CIG_FIFO_FULL_CNT 2'h3
`define CIG_LEC_RST 3'h0
`define CIG_RDATA_RST 32'h00000000
`define CIG_WARN_LIMIT 9'h060
`define CIG_PASV_LIMIT 9'h07F
`define CIG_BOFF_LIMIT 9'h0FF
`define CIG_HTRANS_NONSEQ 2'h2
`define CIG_HTRANS_SEQ 2'h3

`endif

// ==== hdl/cig_sticky.v ====
// Purpose: one sticky status flag, hardware set, software clear
// Assumes: set and clear come from the hclk domain
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps

module cig_sticky #(
  parameter RST_VAL = 1'b0
) (
  input wire hclk,
  input wire hresetn,
  input wire set,
  input wire clr,
  output reg flag_r
);

  reg flag_nxt;

  always @* begin
    flag_nxt = flag_r;
    if (clr) begin
      flag_nxt = 1'b0;
    end
    if (set) begin
      flag_nxt = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= RST_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule // cig_sticky

// ==== test/cig_irq_sink.sv ====
// Purpose: far-side model, latches interrupt request levels
// Assumes: requests are levels on hclk
// Notes: pending bits follow the request lines each cycle
`timescale 1ns/1ps
module cig_irq_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [5:0] irq,
  output logic [5:0] pend_r
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pend_r <= 6'h00;
    else pend_r <= irq;
  end
endmodule // cig_irq_sink

// ==== test/cig_check_assertions.sv ====
// Purpose: port-level checks of the interrupt gating block
// Assumes: one clock domain, zero wait bus slave
// Notes: bound to cig_top
`timescale 1ns/1ps
module cig_check #(parameter CNT_W = 2, parameter TXMB_N = 3) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [TXMB_N-1:0] tx_request_done,
  input wire logic [CNT_W-1:0] rx0_msg_count,
  input wire logic [CNT_W-1:0] rx1_msg_count,
  input wire logic [8:0] tx_fault_counter,
  input wire logic [7:0] rx_fault_counter,
  input wire logic wake_event,
  input wire logic doze_ack_event,
  input wire logic irq_tx,
  input wire logic irq_rx0,
  input wire logic irq_rx1,
  input wire logic irq_wake,
  input wire logic irq_doze,
  input wire logic warning_state,
  input wire logic passive_state,
  input wire logic busoff_state
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // sticky full or overrun flags can only exist once a fifo reached full
  logic rx0_was_full, rx1_was_full;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx0_was_full <= 1'b0;
      rx1_was_full <= 1'b0;
    end else begin
      if (rx0_msg_count == 2'h3) rx0_was_full <= 1'b1;
      if (rx1_msg_count == 2'h3) rx1_was_full <= 1'b1;
    end
  end
  sequence rx0_cause;
    $past(rx0_msg_count) != 0 || rx0_was_full;
  endsequence
  sequence rx1_cause;
    $past(rx1_msg_count) != 0 || rx1_was_full;
  endsequence
  chk_warn_limit: assert property (warning_state ==
    (tx_fault_counter >= 9'h060 || rx_fault_counter >= 8'h60))
    else $error("warning state wrong");
  chk_passive_limit: assert property (passive_state ==
    (tx_fault_counter >= 9'h07F || rx_fault_counter >= 8'h7F))
    else $error("passive state wrong");
  chk_busoff_limit: assert property (
    busoff_state == (tx_fault_counter > 9'h0FF))
    else $error("busoff state wrong");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  chk_tx_cause: assert property (
    irq_tx |-> $past(|tx_request_done))
    else $error("tx request without cause");
  chk_rx0_cause: assert property ($rose(irq_rx0) |-> rx0_cause)
    else $error("fifo0 request without cause");
  chk_rx1_cause: assert property ($rose(irq_rx1) |-> rx1_cause)
    else $error("fifo1 request without cause");
  chk_wake_cause: assert property (irq_wake |-> $past(wake_event))
    else $error("wake request without cause");
  chk_doze_cause: assert property (
    irq_doze |-> $past(doze_ack_event))
    else $error("doze request without cause");
endmodule // cig_check
bind cig_top cig_check #(.CNT_W(CNT_W), .TXMB_N(TXMB_N)) cig_check_i (
  .hclk, .hresetn, .hreadyout, .hresp, .tx_request_done, .rx0_msg_count,
  .rx1_msg_count, .tx_fault_counter, .rx_fault_counter, .wake_event,
  .doze_ack_event, .irq_tx, .irq_rx0, .irq_rx1, .irq_wake, .irq_doze,
  .warning_state, .passive_state, .busoff_state);

// ==== test/test_can_interrupt_enable_gating.sv ====
// Purpose: self-checking bench for cig_top
// Assumes: single ahb slave, hready tied to hreadyout
// Notes: random causes and enables from a fixed seed
`timescale 1ns/1ps
module test_can_interrupt_enable_gating;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, c0 = 0, c1 = 0;
  logic [2:0] hsize = 3'h2, tdone = 0, lc = 0;
  logic [8:0] txc = 0;
  logic [2:0] lec_exp = 0;
  logic [7:0] rxc = 0;
  logic a0 = 0, a1 = 0, lu = 0, wk = 0, dz = 0, hreadyout, hresp;
  logic it, ir0, ir1, ie, iw, id, ws, ps, bs;
  logic [5:0] pend;
  logic [31:0] en;
  logic [31:0] exp_q[$];
  logic [31:0] obs_q[$];
  string nm_q[$];
  int errors = 0, n_tests = 0;
  event seen;
  cig_top cig_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .tx_request_done(tdone), .rx0_msg_count(c0), .rx0_msg_arrive(a0),
    .rx1_msg_count(c1), .rx1_msg_arrive(a1), .tx_fault_counter(txc),
    .rx_fault_counter(rxc), .last_fault_code(lc), .last_code_update(lu),
    .wake_event(wk), .doze_ack_event(dz), .irq_tx(it), .irq_rx0(ir0),
    .irq_rx1(ir1), .irq_err(ie), .irq_wake(iw), .irq_doze(id),
    .warning_state(ws), .passive_state(ps), .busoff_state(bs));
  cig_irq_sink cig_irq_sink_i (.hclk, .hresetn,
    .irq({id, iw, ie, ir1, ir0, it}), .pend_r(pend));
  initial forever #2.5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic note(string nm, logic [31:0] s, logic [31:0] e);
    nm_q.push_back(nm);
    obs_q.push_back(s);
    exp_q.push_back(e);
    -> seen;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e, string nm);
    bus(1'b0, a, 32'h0);
    note(nm, rd, e);
  endtask
  always @(seen) while (exp_q.size() > 0)
    chk(nm_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
  ////////////////////////////////////////////////////////////////////////
  task automatic round();
    logic w, p, b, ef, f0, f1, u, v0, v1;
    logic [2:0] code;
    logic [31:0] iv, ov, es;
    en = $urandom & 32'h00038F7F;
    u = $urandom;
    v0 = $urandom;
    v1 = $urandom;
    code = 3'h1 + $urandom % 7;
    bus(1'b1, 8'h14, en);
    @(posedge hclk);
    tdone <= $urandom; c0 <= $urandom; c1 <= $urandom; lu <= u;
    txc <= $urandom; rxc <= $urandom; wk <= $urandom; dz <= $urandom;
    a0 <= v0; a1 <= v1; lc <= code;
    @(posedge hclk);
    a0 <= 1'b0; a1 <= 1'b0; lu <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    // pulses have dropped by now, so their drawn values are used
    if (u) lec_exp = code;
    w = txc >= 96 || rxc >= 96;
    p = txc >= 127 || rxc >= 127;
    b = txc > 255;
    ef = w & en[8] | p & en[9] | b & en[10] | u & en[11];
    f0 = (c0 == 2'h3);
    f1 = (c1 == 2'h3);
    iv = {23'h0, b, p, w, dz & en[17], wk & en[16],
      ef & en[15],
      (c1 != 0) & en[4] | f1 & en[5] | f1 & v1 & en[6],
      (c0 != 0) & en[1] | f0 & en[2] | f0 & v0 & en[3],
      (|tdone) & en[0]};
    ov = {23'h0, bs, ps, ws, id, iw, ie, ir1, ir0, it};
    note("irq vector", ov, iv);
    note("irq pending", {26'h0, pend}, {26'h0, iv[5:0]});
    es = {rxc, txc[7:0], 9'h0, lec_exp, 1'b0, b, p, w};
    rd_chk(8'h04, {27'h0, dz, wk, ef, 2'h0}, "main status");
    rd_chk(8'h08, {29'h0, tdone}, "tx status");
    rd_chk(8'h0C, {27'h0, f0 & v0, f0, 1'b0, c0}, "fifo0 status");
    rd_chk(8'h10, {27'h0, f1 & v1, f1, 1'b0, c1}, "fifo1 status");
    rd_chk(8'h18, es, "error status");
    @(posedge hclk);
    tdone <= 0; c0 <= 0; c1 <= 0; txc <= 0; rxc <= 0; wk <= 0; dz <= 0;
    bus(1'b1, 8'h0C, 32'h00000018);
    bus(1'b1, 8'h10, 32'h00000018);
    bus(1'b1, 8'h04, 32'h00000004);
    rd_chk(8'h04, 32'h00000000, "error flag clear");
    rd_chk(8'h0C, 32'h00000000, "fifo0 flags clear");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(65622));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'h14, 32'h00000000, "enable reset");
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h00038F7F, "enable mask");
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h00000000, "unmapped");
    repeat (60) round();
    @(posedge hclk);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    close_out();
  end
endmodule // test_can_interrupt_enable_gating
